//--- verilog/lbce_core.sv
// Added by the designer: the register offsets and register access over AHB-Lite.
`timescale 1ns/1ns
`default_nettype none

module lbce_core #(
	parameter int unsigned STACK_DEPTH = lbce_pkg::STACK_DEPTH
) (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        ce,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp
);

	localparam int unsigned SP_W = $clog2(STACK_DEPTH);

	typedef enum logic [1:0] {ST_IDLE, ST_DATA, ST_EXEC1, ST_EXEC2} lbce_state_e;

	lbce_state_e           state_r;
	lbce_pkg::lbce_ahb_req_s req_r;
	lbce_pkg::lbce_instr_s instr_r;
	logic [7:0]            acc_r;
	logic                  zero_flag_r;
	logic                  skip_pend_r;
	logic [8:0]            pc_r;
	logic [7:0]            pc_hi_buf_r;
	logic [SP_W-1:0]       sp_r;
	logic [8:0]            stack_r [STACK_DEPTH];
	logic [31:0]           hrdata_r;
	logic                  hreadyout_r;

	logic                  rf_we;
	logic [5:0]            rf_waddr;
	logic [7:0]            rf_wdata;
	logic [5:0]            rf_raddr;
	logic [7:0]            rf_rdata;

	lbce_pkg::lbce_sel_e   bus_sel;
	logic                  bus_dreg;
	logic                  wr_fire;
	logic                  ex_fire;
	logic                  discard;
	logic [7:0]            bit_mask;
	logic                  test_bit;
	logic [7:0]            and_res;
	logic [31:0]           rd_val;

	function automatic lbce_pkg::lbce_sel_e reg_sel(input logic [11:0] a);
		unique case (a)
			lbce_pkg::OFS_INSTR:  return lbce_pkg::SEL_INSTR;
			lbce_pkg::OFS_ACC:    return lbce_pkg::SEL_ACC;
			lbce_pkg::OFS_STATUS: return lbce_pkg::SEL_STATUS;
			lbce_pkg::OFS_PC:     return lbce_pkg::SEL_PC;
			lbce_pkg::OFS_PC_HI_BUF: return lbce_pkg::SEL_PC_HI_BUF;
			lbce_pkg::OFS_SP:     return lbce_pkg::SEL_SP;
			lbce_pkg::OFS_TOS:    return lbce_pkg::SEL_TOS;
			default:              return lbce_pkg::SEL_NONE;
		endcase
	endfunction

	function automatic logic is_dreg(input logic [11:0] a);
		return a >= lbce_pkg::OFS_DREG_BASE && a <= lbce_pkg::OFS_DREG_LAST && a[1:0] == 2'h0;
	endfunction

	assign bus_sel  = reg_sel(req_r.addr);
	assign bus_dreg = is_dreg(req_r.addr);
	assign wr_fire  = state_r == ST_DATA && req_r.write;
	assign ex_fire  = state_r == ST_EXEC1;
	// A word arriving while a skip is pending is the prefetched one and runs as a no-op.
	assign discard  = skip_pend_r;
	assign bit_mask = 8'h01 << instr_r.bitpos;
	assign test_bit = rf_rdata[instr_r.bitpos];
	assign and_res  = acc_r & ((instr_r.opcode == lbce_pkg::OP_AND_IMM) ?
		lbce_pkg::lbce_imm(instr_r) : rf_rdata);

	always_comb begin
		rf_raddr = (state_r == ST_DATA) ? req_r.addr[7:2] : instr_r.addr;
		rf_we    = 1'b0;
		rf_waddr = instr_r.addr;
		rf_wdata = rf_rdata;
		if (wr_fire && bus_dreg) begin
			rf_we    = 1'b1;
			rf_waddr = req_r.addr[7:2];
			rf_wdata = hwdata[7:0];
		end else if (ex_fire && !discard) begin
			unique case (instr_r.opcode)
				lbce_pkg::OP_AND_REG: begin
					rf_we    = instr_r.dest;
					rf_wdata = and_res;
				end
				lbce_pkg::OP_BIT_CLR: begin
					rf_we    = 1'b1;
					rf_wdata = rf_rdata & ~bit_mask;
				end
				lbce_pkg::OP_BIT_SET: begin
					rf_we    = 1'b1;
					rf_wdata = rf_rdata | bit_mask;
				end
				default: begin
					rf_we = 1'b0;
				end
			endcase
		end
	end

	lbce_regfile #(
		.DW (lbce_pkg::DATA_W),
		.AW (lbce_pkg::RADDR_W),
		.N  (lbce_pkg::NUM_REGS)
	) u_regfile (
		.hclk  (hclk),
		.ce    (ce),
		.we    (rf_we),
		.waddr (rf_waddr),
		.wdata (rf_wdata),
		.raddr (rf_raddr),
		.rdata (rf_rdata)
	);

	always_comb begin
		rd_val = 32'h00000000;
		if (bus_dreg) begin
			rd_val[7:0] = rf_rdata;
		end else begin
			unique case (bus_sel)
				lbce_pkg::SEL_INSTR:  rd_val[15:0] = instr_r;
				lbce_pkg::SEL_ACC:    rd_val[7:0] = acc_r;
				lbce_pkg::SEL_STATUS: begin
					rd_val[lbce_pkg::STAT_ZERO_BIT] = zero_flag_r;
					rd_val[lbce_pkg::STAT_SKIP_BIT] = skip_pend_r;
				end
				lbce_pkg::SEL_PC:     rd_val[8:0] = pc_r;
				lbce_pkg::SEL_PC_HI_BUF: rd_val[7:0] = pc_hi_buf_r;
				lbce_pkg::SEL_SP:     rd_val[SP_W-1:0] = sp_r;
				lbce_pkg::SEL_TOS:    rd_val[8:0] = stack_r[sp_r - SP_W'(1)];
				lbce_pkg::SEL_NONE:   rd_val = 32'h00000000;
			endcase
		end
	end

	// Bus sequencing; the data phase is stretched over execution, so a new word cannot overrun.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_r     <= ST_IDLE;
			req_r       <= '0;
			instr_r     <= lbce_pkg::INSTR_RST;
			hrdata_r    <= 32'h00000000;
			hreadyout_r <= 1'b1;
		end else if (ce) begin
			unique case (state_r)
				ST_IDLE: begin
					if (hsel && hready && (htrans & lbce_pkg::HTRANS_NONSEQ_BIT) != 2'h0) begin
						req_r       <= {hwrite, haddr[11:0]};
						state_r     <= ST_DATA;
						hreadyout_r <= 1'b0;
					end
				end
				ST_DATA: begin
					if (req_r.write && bus_sel == lbce_pkg::SEL_INSTR) begin
						instr_r <= hwdata[15:0];
						state_r <= ST_EXEC1;
					end else begin
						if (!req_r.write) begin
							hrdata_r <= rd_val;
						end
						state_r     <= ST_IDLE;
						hreadyout_r <= 1'b1;
					end
				end
				ST_EXEC1: begin
					if (!discard && (instr_r.opcode == lbce_pkg::OP_CALL ||
						(instr_r.opcode == lbce_pkg::OP_SKIP_CLR && !test_bit))) begin
						state_r <= ST_EXEC2;
					end else begin
						state_r     <= ST_IDLE;
						hreadyout_r <= 1'b1;
					end
				end
				ST_EXEC2: begin
					state_r     <= ST_IDLE;
					hreadyout_r <= 1'b1;
				end
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			acc_r <= lbce_pkg::ACC_RST;
		end else if (ce) begin
			if (wr_fire && bus_sel == lbce_pkg::SEL_ACC) begin
				acc_r <= hwdata[7:0];
			end else if (ex_fire && !discard && instr_r.opcode == lbce_pkg::OP_AND_IMM) begin
				acc_r <= and_res;
			end else if (ex_fire && !discard && instr_r.opcode == lbce_pkg::OP_AND_REG &&
				!instr_r.dest) begin
				acc_r <= and_res;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			zero_flag_r <= 1'b0;
		end else if (ce) begin
			if (ex_fire && !discard && (instr_r.opcode == lbce_pkg::OP_AND_REG ||
				instr_r.opcode == lbce_pkg::OP_AND_IMM)) begin
				zero_flag_r <= and_res == 8'h00;
			end else if (wr_fire && bus_sel == lbce_pkg::SEL_STATUS) begin
				zero_flag_r <= hwdata[lbce_pkg::STAT_ZERO_BIT];
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			skip_pend_r <= 1'b0;
		end else if (ce && ex_fire) begin
			if (discard) begin
				skip_pend_r <= 1'b0;
			end else if (instr_r.opcode == lbce_pkg::OP_SKIP_CLR) begin
				skip_pend_r <= !test_bit;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pc_r <= lbce_pkg::PC_RST;
		end else if (ce) begin
			if (wr_fire && bus_sel == lbce_pkg::SEL_PC) begin
				pc_r <= hwdata[8:0];
			end else if (ex_fire && !discard && instr_r.opcode == lbce_pkg::OP_CALL) begin
				pc_r <= {pc_hi_buf_r[0], lbce_pkg::lbce_imm(instr_r)};
			end else if (ex_fire) begin
				pc_r <= pc_r + 9'h001;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pc_hi_buf_r <= lbce_pkg::PC_HI_BUF_RST;
		end else if (ce && wr_fire && bus_sel == lbce_pkg::SEL_PC_HI_BUF) begin
			pc_hi_buf_r <= hwdata[7:0];
		end
	end

	// The stack wraps silently on overflow; software owns the depth budget.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sp_r <= '0;
		end else if (ce) begin
			if (wr_fire && bus_sel == lbce_pkg::SEL_SP) begin
				sp_r <= hwdata[SP_W-1:0];
			end else if (ex_fire && !discard && instr_r.opcode == lbce_pkg::OP_CALL) begin
				sp_r <= sp_r + SP_W'(1);
			end
		end
	end

	always_ff @(posedge hclk) begin
		if (ce && ex_fire && !discard && instr_r.opcode == lbce_pkg::OP_CALL) begin
			stack_r[sp_r] <= pc_r + 9'h001;
		end
	end

	assign hrdata    = hrdata_r;
	assign hreadyout = hreadyout_r;
	assign hresp     = 1'b0;

	logic op_go;
	assign op_go = ex_fire && !discard && ce;

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	property p_and_reg_acc;
		op_go && instr_r.opcode == lbce_pkg::OP_AND_REG && !instr_r.dest |=>
			acc_r == ($past(acc_r) & $past(rf_rdata));
	endproperty
	a_and_reg_acc: assert property (p_and_reg_acc) else $error("register AND wrong acc");

	property p_and_reg_dest;
		op_go && instr_r.opcode == lbce_pkg::OP_AND_REG && instr_r.dest |->
			rf_we && rf_wdata == (acc_r & rf_rdata) ##1 $stable(acc_r);
	endproperty
	a_and_reg_dest: assert property (p_and_reg_dest) else $error("register AND bad dest");

	property p_and_imm;
		op_go && instr_r.opcode == lbce_pkg::OP_AND_IMM |->
			!rf_we ##1 acc_r == ($past(acc_r) & {$past(instr_r.bitpos[1:0]), $past(instr_r.addr)});
	endproperty
	a_and_imm: assert property (p_and_imm) else $error("immediate AND wrong");

	property p_bit_clr;
		op_go && instr_r.opcode == lbce_pkg::OP_BIT_CLR |->
			rf_we && rf_wdata[instr_r.bitpos] == 1'b0 &&
			(rf_wdata | bit_mask) == (rf_rdata | bit_mask) ##1 $stable(zero_flag_r);
	endproperty
	a_bit_clr: assert property (p_bit_clr) else $error("bit clear wrong");

	property p_bit_set;
		op_go && instr_r.opcode == lbce_pkg::OP_BIT_SET |->
			rf_we && rf_wdata[instr_r.bitpos] == 1'b1 &&
			(rf_wdata & ~bit_mask) == (rf_rdata & ~bit_mask) ##1 $stable(zero_flag_r);
	endproperty
	a_bit_set: assert property (p_bit_set) else $error("bit set wrong");

	property p_skip_test;
		op_go && instr_r.opcode == lbce_pkg::OP_SKIP_CLR |=> skip_pend_r == !$past(test_bit);
	endproperty
	a_skip_test: assert property (p_skip_test) else $error("skip decision wrong");

	property p_skip_discard;
		ex_fire && discard && ce |-> !rf_we ##1 !skip_pend_r && $stable(acc_r) && $stable(sp_r);
	endproperty
	a_skip_discard: assert property (p_skip_discard) else $error("skipped word acted");

	property p_two_cycle;
		op_go && (instr_r.opcode == lbce_pkg::OP_CALL ||
			(instr_r.opcode == lbce_pkg::OP_SKIP_CLR && !test_bit)) |=>
			state_r == ST_EXEC2 && !hreadyout_r;
	endproperty
	a_two_cycle: assert property (p_two_cycle) else $error("two-cycle op too short");

	property p_call_push;
		op_go && instr_r.opcode == lbce_pkg::OP_CALL |=>
			sp_r == $past(sp_r) + SP_W'(1) && stack_r[$past(sp_r)] == $past(pc_r) + 9'h001;
	endproperty
	a_call_push: assert property (p_call_push) else $error("call push wrong");

	property p_call_pc;
		op_go && instr_r.opcode == lbce_pkg::OP_CALL |=>
			pc_r == {$past(pc_hi_buf_r[0]), $past(instr_r.bitpos[1:0]), $past(instr_r.addr)};
	endproperty
	a_call_pc: assert property (p_call_pc) else $error("call target wrong");

	property p_zero_flag;
		op_go && (instr_r.opcode == lbce_pkg::OP_AND_REG || instr_r.opcode == lbce_pkg::OP_AND_IMM)
			|=> zero_flag_r == ($past(and_res) == 8'h00);
	endproperty
	a_zero_flag: assert property (p_zero_flag) else $error("zero flag wrong");

	c_call:      cover property (op_go && instr_r.opcode == lbce_pkg::OP_CALL);
	c_skip:      cover property (op_go && instr_r.opcode == lbce_pkg::OP_SKIP_CLR && !test_bit);
	c_discard:   cover property (ex_fire && discard && ce);
	c_and_dest1: cover property (op_go && instr_r.opcode == lbce_pkg::OP_AND_REG && instr_r.dest);

endmodule

`default_nettype wire

//--- verilog/lbce_pkg.sv
`default_nettype none

package lbce_pkg;

	localparam int unsigned DATA_W      = 8;
	localparam int unsigned PC_W        = 9;
	localparam int unsigned RADDR_W     = 6;
	localparam int unsigned NUM_REGS    = 64;
	localparam int unsigned STACK_DEPTH = 8;
	localparam int unsigned INSTR_W     = 16;
	localparam int unsigned DEC_W       = 12;

	localparam logic [11:0] OFS_INSTR     = 12'h000;
	localparam logic [11:0] OFS_ACC       = 12'h004;
	localparam logic [11:0] OFS_STATUS    = 12'h008;
	localparam logic [11:0] OFS_PC        = 12'h00C;
	localparam logic [11:0] OFS_PC_HI_BUF = 12'h010;
	localparam logic [11:0] OFS_SP        = 12'h014;
	localparam logic [11:0] OFS_TOS       = 12'h018;
	localparam logic [11:0] OFS_DREG_BASE = 12'h100;
	localparam logic [11:0] OFS_DREG_LAST = 12'h1FC;

	localparam int unsigned STAT_ZERO_BIT = 0;
	localparam int unsigned STAT_SKIP_BIT = 1;

	localparam logic [7:0]  ACC_RST    = 8'h00;
	localparam logic [8:0]  PC_RST     = 9'h000;
	localparam logic [7:0]  PC_HI_BUF_RST = 8'h00;
	localparam logic [15:0] INSTR_RST  = 16'h0000;
	localparam logic [1:0]  HTRANS_NONSEQ_BIT = 2'h2;

	typedef enum logic [3:0] {
		OP_NOP      = 4'h0,
		OP_AND_REG  = 4'h1,
		OP_AND_IMM  = 4'h2,
		OP_BIT_CLR  = 4'h3,
		OP_BIT_SET  = 4'h4,
		OP_SKIP_CLR = 4'h5,
		OP_CALL     = 4'h6
	} lbce_op_e;

	typedef enum logic [2:0] {
		SEL_NONE,
		SEL_INSTR,
		SEL_ACC,
		SEL_STATUS,
		SEL_PC,
		SEL_PC_HI_BUF,
		SEL_SP,
		SEL_TOS
	} lbce_sel_e;

	// The immediate and call target overlay the low byte of the word.
	typedef struct packed {
		lbce_op_e   opcode;
		logic [1:0] spare;
		logic       dest;
		logic [2:0] bitpos;
		logic [5:0] addr;
	} lbce_instr_s;

	typedef struct packed {
		logic        write;
		logic [11:0] addr;
	} lbce_ahb_req_s;

	function automatic logic [7:0] lbce_imm(input lbce_instr_s ins);
		return {ins.bitpos[1:0], ins.addr};
	endfunction

endpackage

`default_nettype wire

//--- verilog/lbce_regfile.sv
`timescale 1ns/1ns
`default_nettype none

// Data memory with an asynchronous read, so an operand is usable in the cycle it is addressed.
module lbce_regfile #(
	parameter int unsigned DW = 8,
	parameter int unsigned AW = 6,
	parameter int unsigned N  = 64
) (
	input  wire logic          hclk,
	input  wire logic          ce,
	input  wire logic          we,
	input  wire logic [AW-1:0] waddr,
	input  wire logic [DW-1:0] wdata,
	input  wire logic [AW-1:0] raddr,
	output logic      [DW-1:0] rdata
);

	logic [DW-1:0] mem [N];

	always_ff @(posedge hclk) begin
		if (ce && we) begin
			mem[waddr] <= wdata;
		end
	end

	assign rdata = mem[raddr];

endmodule

`default_nettype wire

//--- verif/tb_top.sv
`timescale 1ns/1ns
`default_nettype none

module tb_top;
	logic        hclk;
	logic        hresetn;
	logic        ce;
	logic        hsel;
	logic [31:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [2:0]  hsize;
	logic [31:0] hwdata;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic        hresp;
	int          errors;
	int          check_count;
	int          base_cyc;

	lbce_core dut (
		.hclk      (hclk),
		.hresetn   (hresetn),
		.ce        (ce),
		.hsel      (hsel),
		.haddr     (haddr),
		.htrans    (htrans),
		.hwrite    (hwrite),
		.hsize     (hsize),
		.hwdata    (hwdata),
		.hready    (hreadyout),
		.hrdata    (hrdata),
		.hreadyout (hreadyout),
		.hresp     (hresp)
	);

	always #50 hclk = ~hclk;

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", check_count, errors);
		if (errors == 0 && check_count > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask

	// Values are sampled at the falling edge, where the design's outputs have settled,
	// so the result equals what the next rising edge sees without a race.
	task automatic bus(input logic [11:0] a, input logic w, input logic [31:0] wd,
		output logic [31:0] rd, output int cyc);
		logic r;
		cyc = 0;
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {20'h00000, a};
		hwrite <= w;
		do begin
			@(negedge hclk);
			r = hreadyout;
			@(posedge hclk);
			cyc++;
		end while (r !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		do begin
			@(negedge hclk);
			r = hreadyout;
			rd = hrdata;
			@(posedge hclk);
			cyc++;
		end while (r !== 1'b1);
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] rd;
		int          c;
		bus(a, 1'b1, d, rd, c);
	endtask

	task automatic rdchk(input string what, input logic [11:0] a, input logic [31:0] exp);
		logic [31:0] rd;
		int          c;
		bus(a, 1'b0, 32'h00000000, rd, c);
		chk(what, rd, exp);
	endtask

	task automatic ex(input logic [15:0] word, output int cyc);
		logic [31:0] rd;
		bus(lbce_pkg::OFS_INSTR, 1'b1, {16'h0000, word}, rd, cyc);
	endtask

	function automatic logic [15:0] mk(input lbce_pkg::lbce_op_e op, input logic d,
		input logic [2:0] b, input logic [5:0] a);
		return {op, 2'h0, d, b, a};
	endfunction

	function automatic logic [11:0] dra(input logic [5:0] i);
		return lbce_pkg::OFS_DREG_BASE + {4'h0, i, 2'h0};
	endfunction

	task automatic t_reset();
		int          c;
		logic [31:0] rd;
		rdchk("acc", lbce_pkg::OFS_ACC, 32'h00000000);
		rdchk("status", lbce_pkg::OFS_STATUS, 32'h00000000);
		rdchk("pc", lbce_pkg::OFS_PC, 32'h00000000);
		rdchk("pc high buffer", lbce_pkg::OFS_PC_HI_BUF, 32'h00000000);
		rdchk("sp", lbce_pkg::OFS_SP, 32'h00000000);
		wr(12'h020, 32'h000000FF);
		rdchk("unmapped", 12'h020, 32'h00000000);
		chk("hresp", {31'h00000000, hresp}, 32'h00000000);
		ex(16'h0000, base_cyc);
		rdchk("pc after nop", lbce_pkg::OFS_PC, 32'h00000001);
		// A low clock enable in the data phase must stretch a 3-cycle write by 3 cycles.
		fork
			bus(lbce_pkg::OFS_ACC, 1'b1, 32'h00000077, rd, c);
			begin
				@(posedge hclk);
				ce <= 1'b0;
				repeat (3) @(posedge hclk);
				ce <= 1'b1;
			end
		join
		chk("ce stall cycles", c, 32'h00000006);
		rdchk("acc after stall", lbce_pkg::OFS_ACC, 32'h00000077);
		$display("test reset done");
	endtask

	task automatic t_and_reg();
		int c;
		wr(dra(6'h05), 32'h000000AF);
		wr(lbce_pkg::OFS_ACC, 32'h0000005A);
		wr(lbce_pkg::OFS_STATUS, 32'h00000001);
		ex(mk(lbce_pkg::OP_AND_REG, 1'b0, 3'h0, 6'h05), c);
		rdchk("and acc", lbce_pkg::OFS_ACC, 32'h0000000A);
		rdchk("and src kept", dra(6'h05), 32'h000000AF);
		rdchk("and z clear", lbce_pkg::OFS_STATUS, 32'h00000000);
		chk("and cycles", c, base_cyc);
		wr(dra(6'h3F), 32'h000000A5);
		ex(mk(lbce_pkg::OP_AND_REG, 1'b1, 3'h0, 6'h3F), c);
		rdchk("and reg dest", dra(6'h3F), 32'h00000000);
		rdchk("and acc kept", lbce_pkg::OFS_ACC, 32'h0000000A);
		rdchk("and z set", lbce_pkg::OFS_STATUS, 32'h00000001);
		$display("test and register done");
	endtask

	task automatic t_and_imm();
		int c;
		wr(lbce_pkg::OFS_ACC, 32'h0000005A);
		wr(lbce_pkg::OFS_STATUS, 32'h00000001);
		ex(16'h20AF, c);
		rdchk("imm acc", lbce_pkg::OFS_ACC, 32'h0000000A);
		rdchk("imm z clear", lbce_pkg::OFS_STATUS, 32'h00000000);
		ex(16'h20A5, c);
		rdchk("imm acc zero", lbce_pkg::OFS_ACC, 32'h00000000);
		rdchk("imm z set", lbce_pkg::OFS_STATUS, 32'h00000001);
		$display("test and immediate done");
	endtask

	task automatic t_bits();
		int          c;
		logic [7:0]  v;
		wr(lbce_pkg::OFS_STATUS, 32'h00000001);
		wr(lbce_pkg::OFS_ACC, 32'h00000033);
		wr(dra(6'h00), 32'h00000000);
		v = 8'h00;
		for (int b = 0; b < 8; b++) begin
			ex(mk(lbce_pkg::OP_BIT_SET, 1'b0, 3'(b), 6'h00), c);
			v[b] = 1'b1;
			rdchk("bit set", dra(6'h00), {24'h000000, v});
		end
		for (int b = 0; b < 8; b++) begin
			ex(mk(lbce_pkg::OP_BIT_CLR, 1'b0, 3'(b), 6'h00), c);
			v[b] = 1'b0;
			rdchk("bit clear", dra(6'h00), {24'h000000, v});
		end
		rdchk("bit z kept", lbce_pkg::OFS_STATUS, 32'h00000001);
		rdchk("bit acc kept", lbce_pkg::OFS_ACC, 32'h00000033);
		$display("test bit clear and set done");
	endtask

	task automatic t_skip();
		int c;
		wr(dra(6'h07), 32'h0000005A);
		wr(lbce_pkg::OFS_ACC, 32'h000000FF);
		wr(lbce_pkg::OFS_STATUS, 32'h00000000);
		wr(lbce_pkg::OFS_PC, 32'h00000010);
		ex(mk(lbce_pkg::OP_SKIP_CLR, 1'b0, 3'h2, 6'h07), c);
		chk("skip taken cycles", c, base_cyc + 1);
		rdchk("skip pending", lbce_pkg::OFS_STATUS, 32'h00000002);
		ex(16'h2000, c);
		rdchk("skipped word no effect", lbce_pkg::OFS_ACC, 32'h000000FF);
		rdchk("skip pc", lbce_pkg::OFS_PC, 32'h00000012);
		rdchk("pending cleared", lbce_pkg::OFS_STATUS, 32'h00000000);
		ex(mk(lbce_pkg::OP_SKIP_CLR, 1'b0, 3'h3, 6'h07), c);
		chk("skip not taken cycles", c, base_cyc);
		ex(16'h200F, c);
		rdchk("next word runs", lbce_pkg::OFS_ACC, 32'h0000000F);
		rdchk("no skip pc", lbce_pkg::OFS_PC, 32'h00000014);
		$display("test skip done");
	endtask

	task automatic t_call();
		int c;
		wr(lbce_pkg::OFS_PC, 32'h000000A0);
		wr(lbce_pkg::OFS_SP, 32'h00000001);
		wr(lbce_pkg::OFS_PC_HI_BUF, 32'h00000001);
		ex(16'h6034, c);
		chk("call cycles", c, base_cyc + 1);
		rdchk("call pc", lbce_pkg::OFS_PC, 32'h00000134);
		rdchk("call sp", lbce_pkg::OFS_SP, 32'h00000002);
		rdchk("call tos", lbce_pkg::OFS_TOS, 32'h000000A1);
		wr(lbce_pkg::OFS_PC_HI_BUF, 32'h000000FE);
		ex(16'h6077, c);
		rdchk("call pc low page", lbce_pkg::OFS_PC, 32'h00000077);
		rdchk("call sp again", lbce_pkg::OFS_SP, 32'h00000003);
		rdchk("call tos again", lbce_pkg::OFS_TOS, 32'h00000135);
		rdchk("instr readback", lbce_pkg::OFS_INSTR, 32'h00006077);
		$display("test call done");
	endtask

	// The span allows several times the bus traffic of all tests.
	initial begin
		#(5000 * 100);
		errors++;
		$display("[FAIL] watchdog expected done seen timeout");
		give_verdict();
	end

	initial begin
		hclk = 1'b0;
		hresetn = 1'b0;
		ce = 1'b1;
		hsel = 1'b0;
		haddr = 32'h00000000;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h00000000;
		errors = 0;
		check_count = 0;
		base_cyc = 0;
		repeat (5) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		t_reset();
		t_and_reg();
		t_and_imm();
		t_bits();
		t_skip();
		t_call();
		give_verdict();
	end
endmodule

`default_nettype wire
